// >>> hdl/qsr_chan.sv
`timescale 1ns/10ps
module qsr_chan import qsr_pkg::*; #(
    parameter int unsigned LONG_CYC = DLY_LONG_CYC,
    parameter int unsigned SHORT_CYC = DLY_SHORT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic good,
    input wire qsr_dly_sel_t dly_sel,
    input wire logic [CNT_W-1:0] prog_cyc,
    output logic reset_out_n
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] target_eff;
    logic done;

    assign target = (dly_sel == QSR_DLY_LONG) ? CNT_W'(LONG_CYC) :
                    (dly_sel == QSR_DLY_SHORT) ? CNT_W'(SHORT_CYC) : prog_cyc;
    assign target_eff = (target == '0) ? CNT_W'(1) : target;
    assign done = (cnt_q >= target_eff - CNT_W'(1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            reset_out_n <= 1'b0;
        end else if (!good) begin
            cnt_q <= '0;
            reset_out_n <= 1'b0;
        end else if (!reset_out_n) begin
            if (done) begin
                reset_out_n <= 1'b1;
            end else begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end

    property p_assert_now;
        @(posedge clk)
        disable iff (!rst_b)
        !good |=> !reset_out_n;
    endproperty
    a_assert_now: assert property (p_assert_now)
        else $error("reset not asserted at once");

    property p_hold;
        @(posedge clk)
        disable iff (!rst_b)
        $rose(reset_out_n) |-> $past(good);
    endproperty
    a_hold: assert property (p_hold)
        else $error("release without good condition");
endmodule

// >>> hdl/qsr_pkg.sv
// Operation
// - Channel 1 reset low on manual reset or sense 1 low; release after delay.
// - Channel 2 reset low while sense 2 low; release after delay when good.
// - Channel 3 reset low while sense 3 low; release after delay when good.
// - Channel 4 released only with low side above and high side below threshold.
// - Reset stays asserted for the channel delay after release condition becomes true.
// - Assertion is immediate and cancels any release delay in progress.
// - Released channel 1, no kick edge for 610 ms drives timeout low.
// - Timeout stays latched low regardless of kicks or channel 1 release.
// - While channel 1 reset asserted the watchdog never times out.
// - Channel 4 high side asserts reset when above overvoltage threshold.
// - Count starts at channel 1 release; every kick edge restarts full period.
// - Timeout latch cleared only by channel 1 reset assertion.
// - Each channel delay selects 300 ms, 20 ms or programmable value.
package qsr_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned DLY_LONG_MS = 300;
    localparam int unsigned DLY_SHORT_MS = 20;
    localparam int unsigned WDT_MS = 610;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
    localparam int unsigned DLY_LONG_CYC = DLY_LONG_MS * CYC_PER_MS;
    localparam int unsigned DLY_SHORT_CYC = DLY_SHORT_MS * CYC_PER_MS;
    localparam int unsigned WDT_CYC = WDT_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned NUM_CHAN = 4;
    typedef enum logic [1:0] {
        QSR_DLY_LONG,
        QSR_DLY_SHORT,
        QSR_DLY_PROG
    } qsr_dly_sel_t;
endpackage

// >>> hdl/qsr_sync.sv
`timescale 1ns/10ps
module qsr_sync import qsr_pkg::*; #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// >>> hdl/qsr_top.sv
`timescale 1ns/10ps
module qsr_top import qsr_pkg::*; #(
    parameter int unsigned LONG_CYC = DLY_LONG_CYC,
    parameter int unsigned SHORT_CYC = DLY_SHORT_CYC,
    parameter int unsigned WDT_PERIOD_CYC = WDT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic manual_reset_in_n,
    input wire logic chan1_sense_flag,
    input wire logic chan2_sense_flag,
    input wire logic chan3_sense_flag,
    input wire logic chan4_low_sense_flag,
    input wire logic chan4_high_sense_flag,
    input wire logic watchdog_kick_in,
    input wire qsr_dly_sel_t chan1_delay_select,
    input wire qsr_dly_sel_t chan2_delay_select,
    input wire qsr_dly_sel_t chan3_delay_select,
    input wire qsr_dly_sel_t chan4_delay_select,
    input wire logic [CNT_W-1:0] chan1_prog_cyc,
    input wire logic [CNT_W-1:0] chan2_prog_cyc,
    input wire logic [CNT_W-1:0] chan3_prog_cyc,
    input wire logic [CNT_W-1:0] chan4_prog_cyc,
    output logic chan1_reset_out_n,
    output logic chan2_reset_out_n,
    output logic chan3_reset_out_n,
    output logic chan4_reset_out_n,
    output logic watchdog_timeout_out_n
);
    // Counters compare against the period minus one, so smaller periods cannot be served
    if (WDT_PERIOD_CYC < 2 || LONG_CYC < 1 || SHORT_CYC < 1) begin : g_bad_params
        $error("qsr_top: periods too small");
    end

    logic [6:0] raw_in;
    logic [6:0] sync_in;
    logic mr_n_s;
    logic s1_s;
    logic s2_s;
    logic s3_s;
    logic s4l_s;
    logic s4h_s;
    logic kick_s;
    logic kick_d1_q;
    logic kick_edge;
    logic good1;
    logic good2;
    logic good3;
    logic good4;
    logic [CNT_W-1:0] wdt_cnt_q;
    logic wdt_expire;
    logic wdt_clear;
    logic wdt_restart;

    assign raw_in = {watchdog_kick_in, chan4_high_sense_flag, chan4_low_sense_flag,
                     chan3_sense_flag, chan2_sense_flag, chan1_sense_flag,
                     manual_reset_in_n};

    qsr_sync #(.WIDTH(7)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign mr_n_s = sync_in[0];
    assign s1_s = sync_in[1];
    assign s2_s = sync_in[2];
    assign s3_s = sync_in[3];
    assign s4l_s = sync_in[4];
    assign s4h_s = sync_in[5];
    assign kick_s = sync_in[6];

    // Sense flags are high when the rail is above its undervoltage threshold
    assign good1 = mr_n_s & s1_s;
    assign good2 = s2_s;
    assign good3 = s3_s;
    // High-side flag is high above overvoltage, so it asserts reset
    assign good4 = s4l_s & ~s4h_s;

    qsr_chan #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_ch1 (
        .clk(clk), .rst_b(rst_b), .good(good1), .dly_sel(chan1_delay_select),
        .prog_cyc(chan1_prog_cyc), .reset_out_n(chan1_reset_out_n)
    );
    qsr_chan #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_ch2 (
        .clk(clk), .rst_b(rst_b), .good(good2), .dly_sel(chan2_delay_select),
        .prog_cyc(chan2_prog_cyc), .reset_out_n(chan2_reset_out_n)
    );
    qsr_chan #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_ch3 (
        .clk(clk), .rst_b(rst_b), .good(good3), .dly_sel(chan3_delay_select),
        .prog_cyc(chan3_prog_cyc), .reset_out_n(chan3_reset_out_n)
    );
    qsr_chan #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_ch4 (
        .clk(clk), .rst_b(rst_b), .good(good4), .dly_sel(chan4_delay_select),
        .prog_cyc(chan4_prog_cyc), .reset_out_n(chan4_reset_out_n)
    );

    // Edge detect works on the second sync stage only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kick_d1_q <= 1'b0;
        end else begin
            kick_d1_q <= kick_s;
        end
    end

    assign kick_edge = kick_s ^ kick_d1_q;
    assign wdt_expire = (wdt_cnt_q == CNT_W'(WDT_PERIOD_CYC - 1)) && !kick_edge;
    assign wdt_clear = !chan1_reset_out_n;
    // A timed-out counter is parked at zero so a stale count cannot fire again after clear
    assign wdt_restart = wdt_clear || kick_edge || !watchdog_timeout_out_n;

    // Counter is held at zero while channel 1 is in reset, so it restarts at release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_cnt_q <= '0;
        end else if (wdt_restart) begin
            wdt_cnt_q <= '0;
        end else begin
            wdt_cnt_q <= wdt_cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_timeout_out_n <= 1'b1;
        end else if (wdt_clear) begin
            watchdog_timeout_out_n <= 1'b1;
        end else if (wdt_expire) begin
            watchdog_timeout_out_n <= 1'b0;
        end
    end

    property p_wdt_fire;
        @(posedge clk)
        disable iff (!rst_b)
        wdt_expire && chan1_reset_out_n |=> !watchdog_timeout_out_n;
    endproperty
    a_wdt_fire: assert property (p_wdt_fire)
        else $error("watchdog did not time out");

    property p_wdt_no_early;
        @(posedge clk)
        disable iff (!rst_b)
        watchdog_timeout_out_n && !wdt_expire |=> watchdog_timeout_out_n;
    endproperty
    a_wdt_no_early: assert property (p_wdt_no_early)
        else $error("timeout without expiry");

    property p_wdt_fall;
        @(posedge clk)
        disable iff (!rst_b)
        $fell(watchdog_timeout_out_n) |-> $past(wdt_expire);
    endproperty
    a_wdt_fall: assert property (p_wdt_fall)
        else $error("timeout fell without expiry");

    property p_wdt_bound;
        @(posedge clk)
        disable iff (!rst_b)
        wdt_cnt_q <= CNT_W'(WDT_PERIOD_CYC);
    endproperty
    a_wdt_bound: assert property (p_wdt_bound)
        else $error("watchdog count ran past its period");

    property p_wdt_latch;
        @(posedge clk)
        disable iff (!rst_b)
        !watchdog_timeout_out_n && chan1_reset_out_n |=> !watchdog_timeout_out_n;
    endproperty
    a_wdt_latch: assert property (p_wdt_latch)
        else $error("timeout latch lost");

    property p_wdt_in_reset;
        @(posedge clk)
        disable iff (!rst_b)
        !chan1_reset_out_n |=> watchdog_timeout_out_n;
    endproperty
    a_wdt_in_reset: assert property (p_wdt_in_reset)
        else $error("timeout while channel 1 in reset");

    property p_wdt_held;
        @(posedge clk)
        disable iff (!rst_b)
        !chan1_reset_out_n |=> wdt_cnt_q == '0;
    endproperty
    a_wdt_held: assert property (p_wdt_held)
        else $error("watchdog counted while channel 1 in reset");

    property p_wdt_clear;
        @(posedge clk)
        disable iff (!rst_b)
        $rose(watchdog_timeout_out_n) |-> !$past(chan1_reset_out_n);
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("timeout cleared without channel 1 reset");

    property p_kick_restart;
        @(posedge clk)
        disable iff (!rst_b)
        kick_edge |=> wdt_cnt_q == '0;
    endproperty
    a_kick_restart: assert property (p_kick_restart)
        else $error("kick did not restart count");

    property p_kick_src;
        @(posedge clk)
        disable iff (!rst_b)
        $changed(kick_s) |-> kick_edge;
    endproperty
    a_kick_src: assert property (p_kick_src)
        else $error("kick edge missed");

    property p_ch4_ov;
        @(posedge clk)
        disable iff (!rst_b)
        s4h_s |=> !chan4_reset_out_n;
    endproperty
    a_ch4_ov: assert property (p_ch4_ov)
        else $error("overvoltage did not assert channel 4");

    property p_ch4_low;
        @(posedge clk)
        disable iff (!rst_b)
        !s4l_s |=> !chan4_reset_out_n;
    endproperty
    a_ch4_low: assert property (p_ch4_low)
        else $error("undervoltage did not assert channel 4");

    property p_ch1_mr;
        @(posedge clk)
        disable iff (!rst_b)
        !mr_n_s |=> !chan1_reset_out_n;
    endproperty
    a_ch1_mr: assert property (p_ch1_mr)
        else $error("manual reset did not assert channel 1");

    property p_ch1_sense;
        @(posedge clk)
        disable iff (!rst_b)
        !s1_s |=> !chan1_reset_out_n;
    endproperty
    a_ch1_sense: assert property (p_ch1_sense)
        else $error("sense 1 did not assert channel 1");

    property p_ch2;
        @(posedge clk)
        disable iff (!rst_b)
        !s2_s |=> !chan2_reset_out_n;
    endproperty
    a_ch2: assert property (p_ch2)
        else $error("channel 2 not asserted");

    property p_ch3;
        @(posedge clk)
        disable iff (!rst_b)
        !s3_s |=> !chan3_reset_out_n;
    endproperty
    a_ch3: assert property (p_ch3)
        else $error("channel 3 not asserted");

    property p_ch1_rel;
        @(posedge clk)
        disable iff (!rst_b)
        $rose(chan1_reset_out_n) |-> $past(good1);
    endproperty
    a_ch1_rel: assert property (p_ch1_rel)
        else $error("channel 1 released while not good");

    property p_ch2_rel;
        @(posedge clk)
        disable iff (!rst_b)
        $rose(chan2_reset_out_n) |-> $past(good2);
    endproperty
    a_ch2_rel: assert property (p_ch2_rel)
        else $error("channel 2 released while not good");

    property p_ch3_rel;
        @(posedge clk)
        disable iff (!rst_b)
        $rose(chan3_reset_out_n) |-> $past(good3);
    endproperty
    a_ch3_rel: assert property (p_ch3_rel)
        else $error("channel 3 released while not good");

    property p_ch4_rel;
        @(posedge clk)
        disable iff (!rst_b)
        $rose(chan4_reset_out_n) |-> $past(good4);
    endproperty
    a_ch4_rel: assert property (p_ch4_rel)
        else $error("channel 4 released outside the window");

    // Checked only while reset is held, so it has no disable condition
    property p_reset_state;
        @(posedge clk)
        !rst_b ##1 !rst_b |-> !chan1_reset_out_n && !chan2_reset_out_n &&
            !chan3_reset_out_n && !chan4_reset_out_n && watchdog_timeout_out_n;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("outputs not in reset state");

    // Main scenarios
    c_timeout: cover property (@(posedge clk) $fell(watchdog_timeout_out_n));
    c_wdt_clear: cover property (@(posedge clk) $rose(watchdog_timeout_out_n));
    c_kick: cover property (@(posedge clk) kick_edge && chan1_reset_out_n);
    c_ch1_rel: cover property (@(posedge clk) $rose(chan1_reset_out_n));
    c_ch4_rel: cover property (@(posedge clk) $rose(chan4_reset_out_n));
endmodule

// >>> tb/qsr_proc_model.sv
`timescale 1ns/10ps
module qsr_proc_model #(
    parameter int KICK_CYC = 40
) (
    input wire logic clk,
    input wire logic rst_in_n,
    input wire logic en,
    output logic kick
);
    int n;
    initial begin
        kick = 1'b0;
        n = 0;
    end
    // Firmware only services the watchdog while it is out of reset
    always @(posedge clk) begin
        n <= (rst_in_n && en) ? n + 1 : 0;
        if (n == KICK_CYC) begin
            kick <= #1 ~kick;
            n <= 0;
        end
    end
endmodule

// >>> tb/quad_supervisor_reset_watchdog_tb.sv
`timescale 1ns/10ps
module quad_supervisor_reset_watchdog_tb import qsr_pkg::*;;
    `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
    typedef struct {logic [4:0] v; int lo; int hi;} qsr_note_t;
    qsr_note_t q[$];
    qsr_note_t nt;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic en = 1'b1;
    logic kick;
    logic [5:0] sv = 6'b11_1110;
    logic [31:0] p3 = 32'h0000_001e;
    logic [31:0] p4 = 32'h0000_0028;
    wire [4:0] o;
    logic [4:0] prv;
    logic [4:0] last = 5'b0_0001;
    logic [4:0] exp_o = 5'b0_0001;
    int cyc = 0;
    int num_errors = 0;
    int n_compared = 0;
    int seed;
    always #2 clk = ~clk;
    qsr_top #(.LONG_CYC(50), .SHORT_CYC(20), .WDT_PERIOD_CYC(100)) DUT (
        .clk(clk), .rst_b(rst_b), .manual_reset_in_n(sv[5]), .chan1_sense_flag(sv[4]),
        .chan2_sense_flag(sv[3]), .chan3_sense_flag(sv[2]), .chan4_low_sense_flag(sv[1]),
        .chan4_high_sense_flag(sv[0]), .watchdog_kick_in(kick),
        .chan1_delay_select(QSR_DLY_SHORT), .chan2_delay_select(QSR_DLY_LONG),
        .chan3_delay_select(QSR_DLY_PROG), .chan4_delay_select(qsr_dly_sel_t'(2'd3)),
        .chan1_prog_cyc(p4), .chan2_prog_cyc(p4), .chan3_prog_cyc(p3), .chan4_prog_cyc(p4),
        .chan1_reset_out_n(o[4]), .chan2_reset_out_n(o[3]), .chan3_reset_out_n(o[2]),
        .chan4_reset_out_n(o[1]), .watchdog_timeout_out_n(o[0]));
    qsr_proc_model #(.KICK_CYC(40)) PM (.clk(clk), .rst_in_n(o[4]), .en(en), .kick(kick));
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic note(input logic [4:0] ev, input int lo, input int hi);
        q.push_back('{ev, cyc + lo, cyc + hi});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One channel changes per call, so one delay applies
    task automatic apply(input logic [5:0] nv);
        logic [3:0] g;
        logic [4:0] ev;
        int d;
        int dl[4];
        tick(1);
        dl = '{40, int'(p3), 50, 20};
        g = {nv[5] & nv[4], nv[3], nv[2], nv[1] & ~nv[0]};
        d = 0;
        for (int k = 0; k < 4; k++)
            if (g[k] && !exp_o[k+1]) d = dl[k];
        ev = {g, exp_o[0] | ~g[3]};
        sv = nv;
        if (ev !== exp_o) note(ev, d + 1, d + 7);
        exp_o = ev;
    endtask
    // A change counts once it has held two cycles, so paired edges merge into one event
    always @(posedge clk) begin
        cyc <= cyc + 1;
        prv <= o;
        if (rst_b && o !== last && o === prv) begin
            last <= o;
            if (q.size() == 0) begin
                `CHK(o, last)
            end else begin
                nt = q.pop_front();
                `CHK(o, nt.v)
                `CHK(cyc >= nt.lo && cyc <= nt.hi, 1'b1)
            end
        end
        if (cyc > 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        seed = $urandom(32'h0000_ffc6);
        tick(20);
        rst_b = 1'b1;
        note(5'b1_0001, 21, 27);
        note(5'b1_0101, 31, 37);
        note(5'b1_0111, 41, 47);
        note(5'b1_1111, 51, 57);
        exp_o = 5'b1_1111;
        tick(60);
        for (int i = 5; i >= 0; i--) begin
            apply(6'b11_1110 ^ (6'd1 << i));
            tick(8);
            apply(6'b11_1110);
            tick(60);
        end
        apply(6'b11_0110);
        tick(8);
        apply(6'b11_1110);
        tick(10);
        apply(6'b11_0110);
        // The aborted release never shows, so its two notes are withdrawn
        void'(q.pop_back());
        void'(q.pop_back());
        apply(6'b11_1110);
        tick(60);
        en = 1'b0;
        note(5'b1_1110, 55, 110);
        exp_o = 5'b1_1110;
        tick(120);
        en = 1'b1;
        tick(150);
        apply(6'b01_1110);
        en = 1'b0;
        tick(200);
        en = 1'b1;
        apply(6'b11_1110);
        tick(60);
        repeat (4) begin
            apply(6'b11_1010);
            p3 = 32'd5 + ($urandom % 50);
            tick(8);
            apply(6'b11_1110);
            tick(70);
        end
        `CHK(q.size(), 0)
        end_of_test();
    end
endmodule
